/* verification/dscp_host.sv */
/* Behavioural serial host of the config port.
   The bench resolves the shared data line. */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Host model
module dscp_host (
   output logic sclk,
   output logic cs_n,
   output logic h_oe,
   output logic h_d,
   input wire logic sdio
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      h_oe = 1'b0;
      h_d = 1'b0;
   end
   // A short nb cuts the frame in mid-byte
   task automatic xfer(input logic [7:0] ins, input logic lsb, input int nb,
      input logic [7:0] wd, output logic [15:0] rd);
      logic [7:0] v;
      int i;
      rd = 16'h0;
      cs_n = 1'b0;
      #80;
      for (int b = 0; b < nb; b++) begin
         if (b % 8 == 0) v = b ? wd + 8'(b / 8 - 1) : ins;
         i = lsb ? b % 8 : 7 - b % 8;
         h_oe = b < 8 || !ins[7];
         h_d = v[i];
         #160 sclk = 1'b1;
         if (b > 7 && ins[7]) v[i] = sdio;
         #160 sclk = 1'b0;
         if (b % 8 == 7 && b > 7 && ins[7]) rd = {rd[7:0], v};
      end
      #80 cs_n = 1'b1;
      h_oe = 1'b0;
      #400;
   endtask : xfer
endmodule : dscp_host
`default_nettype wire

/* verification/dscp_port_props.sv */
/* Pin checker of the config port.
   Bound into dscp_port; sclk at most mclk/8. */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Checker
module dscp_port_props (
   input wire logic mclk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdio_out,
   input wire logic sdio_oe,
   input wire logic serial_data_out,
   input wire logic serial_data_out_oe,
   input wire dscp_pkg::dscp_mode_t mode
);
   import dscp_pkg::*;
   logic [3:0] rises;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Saturates so long frames cannot wrap back under eight
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) rises <= 4'h0;
      else if (cs_n) rises <= 4'h0;
      else if ($rose(sclk) && rises != 4'hF) rises <= rises + 4'h1;
   end
   float_cs_a: assert property (
      cs_n [*5] |-> !(sdio_oe || serial_data_out_oe)) else $error("driven");
   split_pins_a: assert property (
      serial_data_out_oe |-> !mode.bidir) else $error("out pin in bidir");
   bidir_pin_a: assert property (
      sdio_oe |-> mode.bidir) else $error("data pin in split mode");
   early_oe_a: assert property (
      !cs_n && rises < 4'h8 |-> !(sdio_oe || serial_data_out_oe))
      else $error("driven in instruction");
   first_bit_a: assert property (
      $rose(sdio_oe || serial_data_out_oe) |-> rises == 4'h8)
      else $error("read starts late or early");
   out_hold_a: assert property (
      $rose(sclk) |-> ##1 ($stable(sdio_out) && $stable(serial_data_out)) [*4])
      else $error("output moved while clock high");
   mode_frame_a: assert property (
      $changed(mode) |-> !$past(cs_n, 3)) else $error("mode outside frame");
   reset_val_a: assert property (
      $fell(rst) |-> mode == 2'b00 && !(sdio_oe || serial_data_out_oe))
      else $error("bad reset value");
   cover property ($rose(sdio_oe));
   cover property ($rose(serial_data_out_oe));
   cover property ($changed(mode));
endmodule : dscp_port_props
bind dscp_port dscp_port_props u_props (.mclk, .rst, .sclk, .cs_n,
   .sdio_out, .sdio_oe, .serial_data_out, .serial_data_out_oe, .mode);
`default_nettype wire

/* verification/tb_top.sv */
/* Self-checking bench of the config port.
   Uses dscp_host as the serial master. */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench
module tb_top;
   import dscp_pkg::*;
   typedef struct packed {
      logic [7:0] ins, nb, wd;
      logic [15:0] rd;
      logic [7:0] tw;
   } dscp_row_t;
   logic mclk, rst, sclk, cs_n, h_oe, h_d, sdio_out, sdio_oe, sep_out, sep_oe;
   dscp_mode_t mode;
   logic [7:0] tw [TW_FIRST:TW_LAST];
   logic [15:0] rd;
   int errors = 0;
   int total_checks = 0;
   wire logic sdio_in, host_in;
   dscp_row_t rows [7] = '{'{8'h12, 8'h10, 8'hA5, 16'h0000, 8'h00},
      '{8'h92, 8'h10, 8'h00, 16'h00A5, 8'h00},
      '{8'h21, 8'h18, 8'h5A, 16'h0000, 8'h00},
      '{8'hA1, 8'h18, 8'h00, 16'h5A5B, 8'h00},
      '{8'h31, 8'h10, 8'h77, 16'h0000, 8'h00},
      '{8'h36, 8'h10, 8'h01, 16'h0000, 8'h77},
      '{8'hB1, 8'h10, 8'h00, 16'h0077, 8'h77}};
   // Board pull-ups on both data lines
   assign sdio_in = h_oe ? h_d : (sdio_oe ? sdio_out : 1'b1);
   assign host_in = mode.bidir ? sdio_in : (sep_oe ? sep_out : 1'b1);
   dscp_port dut (.mclk, .rst, .sclk, .cs_n, .sdio_in, .sdio_out, .sdio_oe,
      .serial_data_out(sep_out), .serial_data_out_oe(sep_oe), .mode,
      .tuning_word_active(tw));
   dscp_host host (.sclk, .cs_n, .h_oe, .h_d, .sdio(host_in));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_of_test;
      $display("errors %0d checks %0d", errors, total_checks);
      if (errors == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   initial begin
      #1000000;
      errors++;
      end_of_test();
   end
   initial begin
      rst = 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      #7;
      chk({4'h0, sdio_oe, sep_oe, mode, tw[7'h31]}, 16'h0000);
      foreach (rows[i]) begin
         host.xfer(rows[i].ins, 1'b0, rows[i].nb, rows[i].wd, rd);
         chk(rd, rows[i].rd);
         chk({8'h0, tw[7'h31]}, {8'h0, rows[i].tw});
      end
      host.xfer(8'h00, 1'b0, 16, 8'h40, rd);
      chk({14'h0000, mode}, 16'h0001);
      host.xfer(8'h40, 1'b1, 24, 8'h11, rd);
      host.xfer(8'hC0, 1'b1, 24, 8'h00, rd);
      chk(rd, 16'h1112);
      host.xfer(8'h00, 1'b1, 16, 8'hC0, rd);
      chk({14'h0000, mode}, 16'h0003);
      host.xfer(8'hC1, 1'b1, 16, 8'h00, rd);
      chk(rd, 16'h0012);
      host.xfer(8'h00, 1'b1, 16, 8'h00, rd);
      host.xfer(8'h12, 1'b0, 12, 8'h3C, rd);
      host.xfer(8'h92, 1'b0, 16, 8'h00, rd);
      chk(rd, 16'h00A5);
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire

/* verilog/dscp_pkg.sv */
/*
 Constants and types of the serial configuration port of a dual converter.
 Assumes a 25 MHz system clock that oversamples the serial link pins.
*/
// Notes on behaviour
// - Each cycle opens with eight instruction bits on the first rising edges.
// - Chip select high then low restarts bit timing at the instruction.
// - Data phase carries one or more bytes right after the instruction.
// - A written register updates as soon as its last data bit arrives.
// - Tuning word writes apply only on the update bit.
// - Instruction bit 7 set means read, clear means write.
// - Instruction bits 6 to 0 give the first register address.
// - Later byte addresses are generated inside, direction from bit order.
// - Instruction and write data bits are sampled on serial clock rise.
// - Read data changes on the serial clock falling edge.
// - With chip select high both data outputs float.
// - Port logic is timed by the sample clock, which finds serial clock edges.
// - Port offers one bidirectional pin or separate in and out pins.
// - Register 0x00 bit 7 picks bidirectional mode; output pin then floats.
// - Register 0x00 bit 6 picks LSB first; reset value is MSB first.
// - MSB first decrements address toward 0x00, LSB first increments.
package dscp_pkg;
   localparam int unsigned ADDR_W = 7;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned NREG = 128;
   localparam logic [6:0] COMM_ADDR = 7'h00;
   localparam logic [6:0] UPD_ADDR = 7'h36;
   localparam logic [6:0] TW_FIRST = 7'h30;
   localparam logic [6:0] TW_LAST = 7'h35;
   localparam int unsigned BIDIR_BIT = 7;
   localparam int unsigned LSBF_BIT = 6;
   localparam int unsigned RW_BIT = 7;
   localparam int unsigned UPD_BIT = 0;
   localparam logic [7:0] COMM_RST = 8'h00;
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [2:0] LAST_BIT = 3'h7;
   typedef enum logic [1:0] {
      DSCP_IDLE = 2'b00,
      DSCP_INSTR = 2'b01,
      DSCP_DATA = 2'b11
   } dscp_state_t;
   typedef struct packed {
      logic bidir;
      logic lsb_first;
   } dscp_mode_t;
endpackage : dscp_pkg

/* verilog/dscp_port.sv */
/*
 Serial configuration port: instruction byte then data bytes, register
 array, held-back tuning registers. Assumes sclk, cs_n, sdio_in are
 asynchronous pins oversampled by mclk, at least 8x faster than sclk.
*/
`timescale 1ns/1ps
`default_nettype none
module dscp_port (
   input wire logic mclk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   output logic serial_data_out,
   output logic serial_data_out_oe,
   output dscp_pkg::dscp_mode_t mode,
   output logic [7:0] tuning_word_active [dscp_pkg::TW_FIRST:dscp_pkg::TW_LAST]
);
   import dscp_pkg::*;

   // ==========================================================
   // Pin synchronisers
   // Edges reach the logic three mclk late, so sclk stays at or below mclk/8
   logic [1:0] s_sclk, s_cs, s_din;
   logic sclk_d;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_sclk <= 2'h0;
         s_cs <= 2'h3;
         s_din <= 2'h0;
         sclk_d <= 1'b0;
      end else begin
         s_sclk <= {s_sclk[0], sclk};
         s_cs <= {s_cs[0], cs_n};
         s_din <= {s_din[0], sdio_in};
         sclk_d <= s_sclk[1];
      end
   end
   // Port is timed by serial clock edges found here
   wire rise = s_sclk[1] & ~sclk_d;
   wire fall = ~s_sclk[1] & sclk_d;
   wire cs_act = ~s_cs[1];

   // ==========================================================
   // Protocol state
   dscp_state_t state, next_state;
   logic [2:0] cnt, next_cnt;
   logic [7:0] sh, next_sh;
   logic [6:0] addr, next_addr;
   logic rd, next_rd;
   logic [7:0] tx, next_tx;
   logic dout, next_dout;
   // Set by the first fall of a read, so the host's last bit is not fought
   logic send, next_send;
   logic [7:0] regs [NREG];
   logic [7:0] twa [TW_FIRST:TW_LAST];
   logic wr_en;
   logic [7:0] wr_byte;
   logic lsbf;
   assign lsbf = regs[COMM_ADDR][LSBF_BIT];

   function automatic logic [7:0] rev(input logic [7:0] v);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < DATA_W; i++) r[i] = v[DATA_W - 1 - i];
      return r;
   endfunction : rev

   always_comb begin
      logic [7:0] full;
      logic [7:0] ord;
      full = 8'h00;
      ord = 8'h00;
      next_state = state;
      next_cnt = cnt;
      next_sh = sh;
      next_addr = addr;
      next_rd = rd;
      next_tx = tx;
      next_dout = dout;
      next_send = send;
      wr_en = 1'b0;
      wr_byte = 8'h00;
      case (state)
         DSCP_IDLE: begin
            next_send = 1'b0;
            // Falling chip select restarts at the instruction
            if (cs_act) begin
               next_state = DSCP_INSTR;
               next_cnt = 3'h0;
            end
         end
         DSCP_INSTR: begin
            if (!cs_act) begin
               next_state = DSCP_IDLE;
            end else if (rise) begin
               // Sample on rising edge, shift left so first bit ends at 7
               full = {sh[6:0], s_din[1]};
               next_sh = full;
               next_cnt = cnt + 3'h1;
               if (cnt == LAST_BIT) begin
                  ord = lsbf ? rev(full) : full;
                  next_rd = ord[RW_BIT];
                  next_addr = ord[6:0];
                  next_tx = lsbf ? regs[ord[6:0]] : rev(regs[ord[6:0]]);
                  next_state = DSCP_DATA;
               end
            end
         end
         DSCP_DATA: begin
            if (!cs_act) begin
               next_state = DSCP_IDLE;
            end else begin
               // tx holds bits in send order from bit 0
               if (fall && rd) begin
                  next_send = 1'b1;
                  next_dout = tx[0];
                  next_tx = {1'b0, tx[7:1]};
               end
               if (rise) begin
                  full = {sh[6:0], s_din[1]};
                  next_sh = full;
                  next_cnt = cnt + 3'h1;
                  if (cnt == LAST_BIT) begin
                     wr_byte = lsbf ? rev(full) : full;
                     wr_en = ~rd;
                     // Auto address direction
                     next_addr = lsbf ? addr + 7'h01 : addr - 7'h01;
                     next_tx = lsbf ? regs[next_addr] : rev(regs[next_addr]);
                  end
               end
            end
         end
         default: next_state = DSCP_IDLE;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state <= DSCP_IDLE;
         cnt <= 3'h0;
         sh <= 8'h00;
         addr <= 7'h00;
         rd <= 1'b0;
         tx <= 8'h00;
         dout <= 1'b0;
         send <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         sh <= next_sh;
         addr <= next_addr;
         rd <= next_rd;
         tx <= next_tx;
         dout <= next_dout;
         send <= next_send;
      end
   end

   // ==========================================================
   // Register array; tuning registers staged until update bit
   logic [NREG-1:0] wr_sel;
   logic tw_load;
   always_comb begin
      wr_sel = '0;
      if (wr_en) wr_sel[addr] = 1'b1;
   end
   // Level, not a strobe: staging stays open while the update bit is set
   assign tw_load = regs[UPD_ADDR][UPD_BIT];

   genvar g;
   generate
      for (g = 0; g < NREG; g++) begin : g_reg
         always_ff @(posedge mclk or posedge rst) begin
            if (rst) regs[g] <= (g == COMM_ADDR) ? COMM_RST : REG_RST;
            else if (wr_sel[g]) regs[g] <= wr_byte;
         end
      end
      for (g = TW_FIRST; g <= TW_LAST; g++) begin : g_tw
         always_ff @(posedge mclk or posedge rst) begin
            if (rst) twa[g] <= REG_RST;
            else if (tw_load) twa[g] <= regs[g];
         end
      end
   endgenerate

   // ==========================================================
   // Pin drivers
   logic drive;
   logic next_sdio_oe, next_pin_oe;
   dscp_mode_t next_mode;
   assign drive = send && state == DSCP_DATA && cs_act;
   always_comb begin
      next_mode = '{bidir: regs[COMM_ADDR][BIDIR_BIT], lsb_first: lsbf};
      // Float both when deselected; out pin floats in 3-wire
      next_sdio_oe = drive && next_mode.bidir;
      next_pin_oe = drive && !next_mode.bidir;
   end

   // Every pin leaves a flip-flop, so no decode glitch reaches the board
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sdio_out <= 1'b0;
         sdio_oe <= 1'b0;
         serial_data_out <= 1'b0;
         serial_data_out_oe <= 1'b0;
         mode <= '0;
         tuning_word_active <= '{default: 8'h00};
      end else begin
         sdio_out <= next_dout;
         serial_data_out <= next_dout;
         sdio_oe <= next_sdio_oe;
         serial_data_out_oe <= next_pin_oe;
         mode <= next_mode;
         tuning_word_active <= twa;
      end
   end
endmodule : dscp_port
`default_nettype wire
